//--- cr_current_ref.sv
`timescale 1ns/1ps
`default_nettype none
`include "cr_regs.svh"
module cr_current_ref
  import cr_pkg::*;
#(
  parameter int CHANNELS = 6
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire cr_sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  input wire logic [CHANNELS-1:0] CCO_IN,
  output var cr_drive_t CUR_DRIVE
);
  logic [7:0] ctrl_reg;
  logic [7:0] conf_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic sel_ctrl;
  logic sel_conf;
  logic sink_reg;
  logic range_reg;
  logic enable_reg;
  logic [5:0] count_reg;
  logic gate_reg;
  logic gate_next;
  logic [9:0] mag_reg;
  logic [9:0] mag_next;
  logic [9:0] base_mag;
  logic [5:0] count_now;
  logic [2:0] src_now;
  logic trim_sel;
  logic trim_valid;

  assign sel_ctrl = (SFR_REQ.addr == `CR_SFR_ADDR) && (SFR_REQ.page == `CR_CTRL_PAGE);
  assign sel_conf = (SFR_REQ.addr == `CR_SFR_ADDR) && (SFR_REQ.page == `CR_CONF_PAGE);
  assign count_now = ctrl_reg[`CR_CTRL_COUNT_MSB:`CR_CTRL_COUNT_LSB];
  assign src_now = conf_reg[`CR_CONF_SRC_MSB:`CR_CONF_SRC_LSB];

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ctrl_reg <= `CR_CTRL_RESET;
    end else if (SFR_REQ.wr && sel_ctrl) begin
      ctrl_reg <= SFR_REQ.wdata;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      conf_reg <= `CR_CONF_RESET;
    end else if (SFR_REQ.wr && sel_conf) begin
      conf_reg <= SFR_REQ.wdata & `CR_CONF_WR_MASK;
    end
  end

  always_comb begin
    rdata_next = `CR_RDATA_NONE;
    if (sel_ctrl) begin
      rdata_next = ctrl_reg;
    end else if (sel_conf) begin
      rdata_next = conf_reg & `CR_CONF_WR_MASK;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rdata_reg <= `CR_RDATA_NONE;
    end else if (SFR_REQ.rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign SFR_RDATA = rdata_reg;

  cr_trim_select #(
    .CHANNELS(CHANNELS)
  ) u_trim_select (
    .cco_in(CCO_IN),
    .source_sel(src_now),
    .selected(trim_sel),
    .source_valid(trim_valid)
  );

  assign gate_next = conf_reg[`CR_CONF_EN_BIT] && trim_valid && trim_sel &&
                     (count_now != `CR_COUNT_ZERO);

  always_comb begin
    base_mag = {4'h0, count_now};
    if (ctrl_reg[`CR_CTRL_RANGE_BIT]) begin
      base_mag = {1'b0, count_now, 3'b000};
    end
    mag_next = base_mag;
    if (gate_next) begin
      mag_next = base_mag + (ctrl_reg[`CR_CTRL_RANGE_BIT] ? `CR_TRIM_HIGH : `CR_TRIM_LOW);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      sink_reg <= 1'b0;
      range_reg <= 1'b0;
      count_reg <= `CR_COUNT_ZERO;
      enable_reg <= 1'b0;
    end else begin
      sink_reg <= ctrl_reg[`CR_CTRL_SINK_BIT];
      range_reg <= ctrl_reg[`CR_CTRL_RANGE_BIT];
      count_reg <= count_now;
      enable_reg <= (count_now != `CR_COUNT_ZERO);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      gate_reg <= 1'b0;
      mag_reg <= `CR_MAG_ZERO;
    end else begin
      gate_reg <= gate_next;
      mag_reg <= mag_next;
    end
  end

  assign CUR_DRIVE.sink = sink_reg;
  assign CUR_DRIVE.high_range = range_reg;
  assign CUR_DRIVE.enable = enable_reg;
  assign CUR_DRIVE.step_count = count_reg;
  assign CUR_DRIVE.trim_gate = gate_reg;
  assign CUR_DRIVE.magnitude = mag_reg;

  a_sink_follow: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    ##1 (CUR_DRIVE.sink == $past(ctrl_reg[`CR_CTRL_SINK_BIT])))
    else $error("direction output does not follow control bit");

  a_range_follow: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    ##1 (CUR_DRIVE.high_range == $past(ctrl_reg[`CR_CTRL_RANGE_BIT])))
    else $error("range output does not follow control bit");

  a_count_write: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (SFR_REQ.wr && sel_ctrl) |-> ##2
      (CUR_DRIVE.step_count == $past(SFR_REQ.wdata[`CR_CTRL_COUNT_MSB:`CR_CTRL_COUNT_LSB], 2)))
    else $error("step count not applied two cycles after write");

  a_mag_product: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !CUR_DRIVE.trim_gate |-> (CUR_DRIVE.magnitude == (CUR_DRIVE.high_range ?
      {1'b0, CUR_DRIVE.step_count, 3'b000} : {4'h0, CUR_DRIVE.step_count})))
    else $error("magnitude is not step size times count");

  a_mag_cap: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !CUR_DRIVE.trim_gate |-> (CUR_DRIVE.magnitude <=
      (CUR_DRIVE.high_range ? `CR_HIGH_MAX : `CR_LOW_MAX)))
    else $error("magnitude above range maximum");

  a_enable_count: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    CUR_DRIVE.enable == (CUR_DRIVE.step_count != `CR_COUNT_ZERO))
    else $error("enable does not match non-zero count");

  a_zero_off: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (SFR_REQ.wr && sel_ctrl && (SFR_REQ.wdata == 8'h00)) |-> ##2
      (!CUR_DRIVE.enable && (CUR_DRIVE.magnitude == `CR_MAG_ZERO)))
    else $error("zero write did not disable reference");

  a_trim_off: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !conf_reg[`CR_CONF_EN_BIT] |=> !CUR_DRIVE.trim_gate)
    else $error("trim gate active with fine trim disabled");

  a_trim_route: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (conf_reg[`CR_CONF_EN_BIT] && (src_now <= `CR_SRC_LAST) &&
     (count_now != `CR_COUNT_ZERO)) |=> (CUR_DRIVE.trim_gate == $past(CCO_IN[src_now])))
    else $error("trim gate does not follow selected capture output");

  a_trim_equal: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (CUR_DRIVE.trim_gate && !CUR_DRIVE.high_range && (CUR_DRIVE.step_count[1:0] == 2'b00))
      |-> (CUR_DRIVE.magnitude == {4'h0, CUR_DRIVE.step_count[5:2], 2'b10}))
    else $error("full duty trim is not equal to 10b setting");

  a_conf_unused: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (SFR_REQ.rd && sel_conf) |=> (SFR_RDATA[6:3] == 4'h0))
    else $error("unused config bits read non-zero");

  a_reserved_src: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (src_now > `CR_SRC_LAST) |=> !CUR_DRIVE.trim_gate)
    else $error("reserved source produced trim gate");
endmodule
`default_nettype wire

//--- cr_regs.svh
`ifndef CR_REGS_SVH
`define CR_REGS_SVH

`define CR_SFR_ADDR 8'hB9
`define CR_CTRL_PAGE 8'h00
`define CR_CONF_PAGE 8'h0F
`define CR_CTRL_RESET 8'h00
`define CR_CONF_RESET 8'h00
`define CR_CTRL_SINK_BIT 7
`define CR_CTRL_RANGE_BIT 6
`define CR_CTRL_COUNT_MSB 5
`define CR_CTRL_COUNT_LSB 0
`define CR_CONF_EN_BIT 7
`define CR_CONF_SRC_MSB 2
`define CR_CONF_SRC_LSB 0
`define CR_CONF_WR_MASK 8'h87
`define CR_SRC_LAST 3'h5
`define CR_COUNT_ZERO 6'h00
`define CR_MAG_ZERO 10'h000
`define CR_TRIM_LOW 10'h002
`define CR_TRIM_HIGH 10'h010
`define CR_LOW_MAX 10'h03F
`define CR_HIGH_MAX 10'h1F8
`define CR_RDATA_NONE 8'h00

`endif

//--- cr_pkg.sv
package cr_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cr_sfr_req_t;

  typedef struct packed {
    logic sink;
    logic high_range;
    logic enable;
    logic [5:0] step_count;
    logic trim_gate;
    logic [9:0] magnitude;
  } cr_drive_t;

endpackage

//--- cr_trim_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "cr_regs.svh"
module cr_trim_select
  import cr_pkg::*;
#(
  parameter int CHANNELS = 6
) (
  input wire logic [CHANNELS-1:0] cco_in,
  input wire logic [2:0] source_sel,
  output logic selected,
  output logic source_valid
);
  logic [CHANNELS-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++) begin : g_chan
      assign hit[i] = cco_in[i] && (source_sel == 3'(i));
    end
  endgenerate

  assign source_valid = (source_sel <= `CR_SRC_LAST);
  assign selected = |hit;
endmodule
`default_nettype wire

//--- cr_current_ref_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cr_regs.svh"
module cr_current_ref_test;
  import cr_pkg::*;
  logic clk_sys;
  logic nrst;
  cr_sfr_req_t req;
  logic [7:0] rdata;
  logic [5:0] cco;
  cr_drive_t drive;
  int bad_count;
  int total_checks;
  logic [7:0] ctrl_val;
  logic [7:0] conf_val;
  logic [7:0] rd8;
  logic [7:0] ctrl_tab [6] = '{8'h45, 8'hBF, 8'h7F, 8'h01, 8'hC1, 8'h00};

  cr_current_ref #(.CHANNELS(6)) cr_current_ref_inst (
    .CLK_SYS(clk_sys),
    .NRST(nrst),
    .SFR_REQ(req),
    .SFR_RDATA(rdata),
    .CCO_IN(cco),
    .CUR_DRIVE(drive)
  );

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] seen);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] page, input logic [7:0] data, input logic [7:0] addr);
    req.addr = addr;
    req.page = page;
    req.wdata = data;
    req.wr = 1'b1;
    tick(1);
    req.wr = 1'b0;
    if (addr == `CR_SFR_ADDR && page == `CR_CTRL_PAGE) ctrl_val = data;
    if (addr == `CR_SFR_ADDR && page == `CR_CONF_PAGE) conf_val = data & `CR_CONF_WR_MASK;
    tick(2);
  endtask

  task automatic rd(input logic [7:0] page, input logic [7:0] addr);
    req.addr = addr;
    req.page = page;
    req.rd = 1'b1;
    tick(1);
    req.rd = 1'b0;
    tick(1);
    rd8 = rdata;
  endtask

  // Expected drive from the last accepted register values and the trim inputs.
  function automatic logic [19:0] exp_drive();
    logic gate;
    logic [9:0] step;
    step = ctrl_val[6] ? 10'h008 : 10'h001;
    gate = conf_val[7] && conf_val[2:0] <= `CR_SRC_LAST && ctrl_val[5:0] != 6'h00
      && cco[conf_val[2:0]];
    return {ctrl_val[7], ctrl_val[6], ctrl_val[5:0] != 6'h00, ctrl_val[5:0], gate,
      10'(ctrl_val[5:0] * step + (gate ? step * 10'h002 : 10'h000))};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    cco = 6'h00;
    ctrl_val = 8'h00;
    conf_val = 8'h00;
    bad_count = 0;
    total_checks = 0;
    tick(4);
    nrst = 1'b1;
    tick(1);
    rd(`CR_CTRL_PAGE, `CR_SFR_ADDR);
    chk("ctrl_reset", 20'(`CR_CTRL_RESET), 20'(rd8));
    rd(`CR_CONF_PAGE, `CR_SFR_ADDR);
    chk("conf_reset", 20'(`CR_CONF_RESET), 20'(rd8));
    chk("drive_reset", 20'h00000, drive);
    $display("test reset done");
    foreach (ctrl_tab[i]) begin
      wr(`CR_CTRL_PAGE, ctrl_tab[i], `CR_SFR_ADDR);
      rd(`CR_CTRL_PAGE, `CR_SFR_ADDR);
      chk("ctrl_read", 20'(ctrl_tab[i]), 20'(rd8));
      chk("drive_ctrl", exp_drive(), drive);
    end
    $display("test control done");
    wr(`CR_CONF_PAGE, 8'hFD, `CR_SFR_ADDR);
    rd(`CR_CONF_PAGE, `CR_SFR_ADDR);
    chk("conf_read", 20'h00085, 20'(rd8));
    wr(`CR_CTRL_PAGE, 8'h04, `CR_SFR_ADDR);
    cco = 6'h20;
    tick(2);
    chk("trim_full_duty", 20'(10'h006), 20'(drive.magnitude));
    chk("drive_trim", exp_drive(), drive);
    wr(`CR_CTRL_PAGE, 8'h44, `CR_SFR_ADDR);
    chk("trim_high", 20'(10'h030), 20'(drive.magnitude));
    $display("test trim done");
    for (int s = 0; s < 8; s++) begin
      wr(`CR_CONF_PAGE, 8'h80 | 8'(s), `CR_SFR_ADDR);
      cco = (s < 6) ? 6'(1 << s) : 6'h3F;
      tick(2);
      chk("drive_src_on", exp_drive(), drive);
      cco = (s < 6) ? ~6'(1 << s) : 6'h00;
      tick(2);
      chk("drive_src_off", exp_drive(), drive);
    end
    cco = 6'h3F;
    wr(`CR_CONF_PAGE, 8'h05, `CR_SFR_ADDR);
    chk("drive_trim_off", exp_drive(), drive);
    wr(`CR_CONF_PAGE, 8'h80, `CR_SFR_ADDR);
    wr(`CR_CTRL_PAGE, 8'h00, `CR_SFR_ADDR);
    chk("drive_zero_count", 20'h00000, drive);
    $display("test source select done");
    wr(`CR_CTRL_PAGE, 8'hFF, 8'hBA);
    wr(8'h01, 8'hFF, `CR_SFR_ADDR);
    rd(`CR_CTRL_PAGE, `CR_SFR_ADDR);
    chk("ctrl_unmapped_wr", 20'h00000, 20'(rd8));
    rd(`CR_CTRL_PAGE, 8'hBA);
    chk("read_unmapped", 20'(`CR_RDATA_NONE), 20'(rd8));
    chk("drive_unmapped", exp_drive(), drive);
    $display("test unmapped done");
    wr(`CR_CTRL_PAGE, 8'hC9, `CR_SFR_ADDR);
    chk("drive_pre_reset", exp_drive(), drive);
    nrst = 1'b0;
    tick(2);
    chk("drive_in_reset", 20'h00000, drive);
    nrst = 1'b1;
    ctrl_val = `CR_CTRL_RESET;
    conf_val = `CR_CONF_RESET;
    tick(1);
    chk("drive_after_reset", exp_drive(), drive);
    rd(`CR_CONF_PAGE, `CR_SFR_ADDR);
    chk("conf_after_reset", 20'(`CR_CONF_RESET), 20'(rd8));
    rd(`CR_CTRL_PAGE, `CR_SFR_ADDR);
    chk("ctrl_after_reset", 20'(`CR_CTRL_RESET), 20'(rd8));
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
